// >>> hw/ces_edc_acc.sv
// Purpose: Running CRC-32 and BIP-16 together over data slot words
// Assumes: Restart and update never in the same cycle
// Notes:   Used by both ends so the codes match by construction

`timescale 1ns/100ps

module ces_edc_acc (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// Control
	input  wire logic        restart,
	input  wire logic        update,
	input  wire logic [31:0] data,
	// Results
	output      logic [31:0] crc_value,
	output      logic [15:0] bip_value
);

	logic [31:0] crc_reg;
	logic [31:0] crc_next;
	logic [15:0] bip_reg;
	logic [15:0] bip_next;

	// ----------------------------------------
	// Bit serial CRC step, MSB first
	// ----------------------------------------
	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		logic        fb;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			fb = r[31] ^ d[i];
			r = {r[30:0], 1'b0} ^ (fb ? ces_pkg::CRC_POLY : 32'h00000000);
		end
		return r;
	endfunction

	// Restart seeds, so a frame check never carries the previous frame
	assign crc_next  = restart ? ces_pkg::CRC_SEED : (update ? crc_word(crc_reg, data) : crc_reg);
	assign bip_next  = restart ? ces_pkg::BIP_SEED : (update ? bip_reg ^ data[31:16] ^ data[15:0] : bip_reg);
	assign crc_value = crc_reg ^ ces_pkg::CRC_OUT_XOR;
	assign bip_value = bip_reg;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			crc_reg <= ces_pkg::CRC_SEED;
			bip_reg <= ces_pkg::BIP_SEED;
		end else if (ce) begin
			crc_reg <= crc_next;
			bip_reg <= bip_next;
		end
	end

endmodule

// >>> hw/ces_link_if.sv
// Purpose: Slot word and code group link between source and sink
// Assumes: Both ends on sys_clk
// Notes:   Source drives every signal

`timescale 1ns/100ps

interface ces_link_if;
	logic        word_valid;
	logic [2:0]  word_kind;
	logic [31:0] word_data;
	logic        group_valid;
	logic [9:0]  group_data;

	modport source (
		output word_valid,
		output word_kind,
		output word_data,
		output group_valid,
		output group_data
	);

	modport sink (
		input  word_valid,
		input  word_kind,
		input  word_data,
		input  group_valid,
		input  group_data
	);
endinterface

// >>> hw/ces_pkg.sv
// Purpose: Shared constants for channel error supervision
// Assumes: One system clock for source and sink ends
// Notes:   Slot kinds, check seeds and code group patterns

package ces_pkg;

	// ----------------------------------------
	// Adaptation modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		CES_MODE_GENERIC  = 2'h0,
		CES_MODE_TYPE_ONE = 2'h1,
		CES_MODE_TYPE_TWO = 2'h3,
		CES_MODE_LINE     = 2'h2
	} ces_mode_type;

	// ----------------------------------------
	// Slot word kinds on the link
	// ----------------------------------------
	localparam logic [2:0] KIND_IDLE    = 3'h0;
	localparam logic [2:0] KIND_DATA    = 3'h1;
	localparam logic [2:0] KIND_HEADER  = 3'h2;
	localparam logic [2:0] KIND_TRAILER = 3'h3;
	localparam logic [2:0] KIND_CHECK   = 3'h4;

	// ----------------------------------------
	// Check codes
	// ----------------------------------------
	localparam logic [31:0] CRC_POLY     = 32'h04C11DB7;
	localparam logic [31:0] CRC_SEED     = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_OUT_XOR  = 32'hFFFFFFFF;
	localparam logic [15:0] BIP_SEED     = 16'h0000;
	localparam int          SLOT_SUM_POS = 0;
	localparam int          SLOT_SUM_W   = 8;

	// ----------------------------------------
	// Line code groups
	// ----------------------------------------
	localparam logic [9:0] COMMA_NEG = 10'h0FA;
	localparam logic [9:0] COMMA_POS = 10'h305;
	localparam int         ONES_MIN  = 4;
	localparam int         ONES_MAX  = 6;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] WORD_RST  = 32'h00000000;
	localparam logic [9:0]  GROUP_RST = 10'h000;

endpackage

// >>> hw/ces_sink.sv
// Purpose: Channel sink signal quality supervision
// Assumes: Frame runs from one check slot word to the next
// Notes:   One second tick comes from the local time base
// How it works
// - Compare frame code with next frame's check
// - No violations during server fail or alarm; errored blocks are gated, code group and ordered set flags are not
// - Source sends CRC-32 of data words
// - Recompute CRC-32, flag mismatch
// - Source adds header and trailer sums in type one only
// - Type one: header, trailer or CRC mismatch
// - Type two uses BIP-16 both ends
// - Flag illegal 10-bit code groups
// - Flag invalid ordered set combinations
// - Line mode supervises by code groups only
// - Each second compare count with threshold
// - Threshold above zero, within blocks per second; code flags only a zero threshold, no upper bound is checked
// - Degraded flag follows per second comparison
// - End to end; monitor may tap copy

`timescale 1ns/100ps

module ces_sink #(
	parameter int CNT_W = 24
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	// Configuration and conditions
	input  wire ces_pkg::ces_mode_type mode,
	input  wire logic [CNT_W-1:0]      degrade_threshold,
	input  wire logic                  server_signal_fail,
	input  wire logic                  alarm_indication_defect,
	input  wire logic                  second_tick,
	// Link
	ces_link_if.sink                   link,
	// Anomalies
	output      logic                  near_end_errored_block_flag,
	output      logic                  code_group_fail_flag,
	output      logic                  ordered_set_fail_flag,
	output      logic                  degraded_period_flag,
	output      logic [CNT_W-1:0]      errored_block_count_per_second,
	output      logic                  threshold_invalid
);

	// ----------------------------------------
	// Slot word decode
	// ----------------------------------------
	logic        word_data_seen;
	logic        word_check_seen;
	logic        word_hdr_trl_seen;
	logic [31:0] crc_value;
	logic [15:0] bip_value;
	logic [7:0]  slot_sum;
	logic        line_mode;
	logic        type_one;
	logic        type_two;

	assign word_data_seen    = link.word_valid && link.word_kind == ces_pkg::KIND_DATA;
	assign word_check_seen   = link.word_valid && link.word_kind == ces_pkg::KIND_CHECK;
	assign word_hdr_trl_seen = link.word_valid &&
	                           (link.word_kind == ces_pkg::KIND_HEADER || link.word_kind == ces_pkg::KIND_TRAILER);
	assign slot_sum          = link.word_data[31:24] ^ link.word_data[23:16] ^ link.word_data[15:8];
	assign line_mode         = mode == ces_pkg::CES_MODE_LINE;
	assign type_one          = mode == ces_pkg::CES_MODE_TYPE_ONE;
	assign type_two          = mode == ces_pkg::CES_MODE_TYPE_TWO;

	ces_edc_acc u_acc (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.ce        (ce),
		.restart   (word_check_seen),
		.update    (word_data_seen),
		.data      (link.word_data),
		.crc_value (crc_value),
		.bip_value (bip_value)
	);

	// ----------------------------------------
	// Frame check comparison
	// ----------------------------------------
	logic primed_reg;
	logic primed_next;
	logic frame_bad_reg;
	logic frame_bad_next;
	logic slot_sum_bad;
	logic check_mismatch;
	logic check_code_violation;
	logic violation_gated;
	logic line_anomaly;
	logic errored_block;
	logic cgf_now;
	logic osf_now;

	// First check after reset has no frame behind it, so it is not judged
	assign primed_next = word_check_seen ? 1'b1 : primed_reg;

	assign slot_sum_bad = type_one && word_hdr_trl_seen &&
	                      link.word_data[ces_pkg::SLOT_SUM_POS +: ces_pkg::SLOT_SUM_W] != slot_sum;

	// Header and trailer faults are held until the frame's verdict
	assign frame_bad_next = word_check_seen ? slot_sum_bad : (frame_bad_reg | slot_sum_bad);

	assign check_mismatch = type_two ? (link.word_data[15:0] != bip_value) : (link.word_data != crc_value);

	assign check_code_violation = !line_mode && word_check_seen && primed_reg && (check_mismatch || frame_bad_reg);

	assign violation_gated = check_code_violation && !server_signal_fail && !alarm_indication_defect;

	assign line_anomaly  = line_mode && (cgf_now || osf_now) && !server_signal_fail && !alarm_indication_defect;
	assign errored_block = violation_gated || line_anomaly;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			primed_reg    <= 1'b0;
			frame_bad_reg <= 1'b0;
		end else if (ce) begin
			primed_reg    <= primed_next;
			frame_bad_reg <= frame_bad_next;
		end
	end

	// ----------------------------------------
	// Code group checks
	// ----------------------------------------
	logic       group_legal;
	logic       group_comma;
	logic       after_comma_reg;
	logic       after_comma_next;
	logic [3:0] ones_all;
	logic [3:0] ones_six;
	logic [3:0] ones_four;

	function automatic logic [3:0] count_ones(input logic [9:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 10; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	assign ones_all  = count_ones(link.group_data);
	assign ones_six  = count_ones({4'h0, link.group_data[9:4]});
	assign ones_four = count_ones({6'h00, link.group_data[3:0]});

	// Disparity limits only; running disparity is not tracked here
	assign group_legal = ones_all >= 4'(ces_pkg::ONES_MIN) && ones_all <= 4'(ces_pkg::ONES_MAX) &&
	                     ones_six >= 4'h2 && ones_six <= 4'h4 &&
	                     ones_four >= 4'h1 && ones_four <= 4'h3;
	assign group_comma = link.group_data == ces_pkg::COMMA_NEG || link.group_data == ces_pkg::COMMA_POS;

	assign cgf_now = link.group_valid && !group_legal;

	assign osf_now = link.group_valid && after_comma_reg && (group_comma || !group_legal);

	assign after_comma_next = link.group_valid ? (group_comma && group_legal && !after_comma_reg) : after_comma_reg;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			after_comma_reg <= 1'b0;
		end else if (ce) begin
			after_comma_reg <= after_comma_next;
		end
	end

	// ----------------------------------------
	// One second performance count
	// ----------------------------------------
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [CNT_W-1:0] count_total;
	logic             count_full;
	logic             second_bad;

	// Saturate rather than wrap, a wrapped count would hide a bad second
	assign count_full  = &count_reg;
	assign count_total = (errored_block && !count_full) ? count_reg + CNT_W'(1) : count_reg;

	assign count_next = second_tick ? '0 : count_total;

	assign second_bad = count_total >= degrade_threshold;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= '0;
		end else if (ce) begin
			count_reg <= count_next;
		end
	end

	// ----------------------------------------
	// Anomaly outputs
	// ----------------------------------------
	logic             eb_reg;
	logic             cgf_reg;
	logic             osf_reg;
	logic             dsp_reg;
	logic             dsp_next;
	logic [CNT_W-1:0] ebc_reg;
	logic [CNT_W-1:0] ebc_next;
	logic             thr_bad_reg;

	assign dsp_next = second_tick ? second_bad : dsp_reg;

	assign ebc_next = second_tick ? count_total : ebc_reg;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			eb_reg      <= 1'b0;
			cgf_reg     <= 1'b0;
			osf_reg     <= 1'b0;
			dsp_reg     <= 1'b0;
			ebc_reg     <= '0;
			thr_bad_reg <= 1'b0;
		end else if (ce) begin
			eb_reg      <= errored_block;
			cgf_reg     <= cgf_now;
			osf_reg     <= osf_now;
			dsp_reg     <= dsp_next;
			ebc_reg     <= ebc_next;
			thr_bad_reg <= degrade_threshold == '0;
		end
	end

	assign near_end_errored_block_flag    = eb_reg;
	assign code_group_fail_flag           = cgf_reg;
	assign ordered_set_fail_flag          = osf_reg;
	assign degraded_period_flag           = dsp_reg;
	assign errored_block_count_per_second = ebc_reg;
	assign threshold_invalid              = thr_bad_reg;

endmodule

// >>> hw/ces_source.sv
// Purpose: Far end source that inserts check payload into the stream
// Assumes: User marks where each check slot word goes
// Notes:   Check word carries the code of the previous frame

`timescale 1ns/100ps

module ces_source (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	// Configuration
	input  wire ces_pkg::ces_mode_type mode,
	// User slot words
	input  wire logic                  usr_valid,
	input  wire logic [2:0]            usr_kind,
	input  wire logic [31:0]           usr_data,
	// User code groups
	input  wire logic                  usr_group_valid,
	input  wire logic [9:0]            usr_group,
	// Link
	ces_link_if.source                 link
);

	logic        is_data;
	logic        is_check;
	logic        is_hdr_trl;
	logic [31:0] crc_value;
	logic [15:0] bip_value;
	logic [31:0] check_word;
	logic [7:0]  slot_sum;
	logic [31:0] word_next;
	logic        valid_reg;
	logic [2:0]  kind_reg;
	logic [31:0] data_reg;
	logic        group_valid_reg;
	logic [9:0]  group_reg;

	assign is_data    = usr_valid && usr_kind == ces_pkg::KIND_DATA;
	assign is_check   = usr_valid && usr_kind == ces_pkg::KIND_CHECK;
	assign is_hdr_trl = usr_kind == ces_pkg::KIND_HEADER || usr_kind == ces_pkg::KIND_TRAILER;
	assign slot_sum   = usr_data[31:24] ^ usr_data[23:16] ^ usr_data[15:8];

	ces_edc_acc u_acc (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.ce        (ce),
		.restart   (is_check),
		.update    (is_data),
		.data      (usr_data),
		.crc_value (crc_value),
		.bip_value (bip_value)
	);

	assign check_word = (mode == ces_pkg::CES_MODE_TYPE_TWO) ? {16'h0000, bip_value} : crc_value;

	// ----------------------------------------
	// Word insertion
	// ----------------------------------------
	// check payload inserted
	assign word_next = is_check ? check_word :
	                   (is_hdr_trl && mode == ces_pkg::CES_MODE_TYPE_ONE) ? {usr_data[31:8], slot_sum} :
	                   usr_data;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			valid_reg       <= 1'b0;
			kind_reg        <= ces_pkg::KIND_IDLE;
			data_reg        <= ces_pkg::WORD_RST;
			group_valid_reg <= 1'b0;
			group_reg       <= ces_pkg::GROUP_RST;
		end else if (ce) begin
			valid_reg       <= usr_valid;
			kind_reg        <= usr_kind;
			data_reg        <= word_next;
			group_valid_reg <= usr_group_valid;
			group_reg       <= usr_group;
		end
	end

	assign link.word_valid  = valid_reg;
	assign link.word_kind   = kind_reg;
	assign link.word_data   = data_reg;
	assign link.group_valid = group_valid_reg;
	assign link.group_data  = group_reg;

endmodule

// >>> test/ces_check_sva.sv
// Purpose: Assertions on the source to sink link and the sink outputs
// Assumes: Both ends on sys_clk, ce held high by the bench
// Notes:   Source is correct, so no errored block outside line mode

`timescale 1ns/100ps

module ces_check_sva #(
	parameter int CNT_W = 24
) (
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  resetn,
	input wire logic                  ce,
	// Source user side
	input wire ces_pkg::ces_mode_type mode,
	input wire logic                  usr_valid,
	input wire logic [2:0]            usr_kind,
	input wire logic [31:0]           usr_data,
	input wire logic                  usr_group_valid,
	input wire logic [9:0]            usr_group,
	// Link
	input wire logic                  word_valid,
	input wire logic [2:0]            word_kind,
	input wire logic [31:0]           word_data,
	input wire logic                  group_valid,
	input wire logic [9:0]            group_data,
	// Sink
	input wire logic                  second_tick,
	input wire logic [CNT_W-1:0]      degrade_threshold,
	input wire logic                  near_end_errored_block_flag,
	input wire logic                  code_group_fail_flag,
	input wire logic                  degraded_period_flag,
	input wire logic [CNT_W-1:0]      errored_block_count_per_second
);
	logic [7:0] sum_in;

	assign sum_in = usr_data[31:24] ^ usr_data[23:16] ^ usr_data[15:8];

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_word_delay: assert property (ce && usr_valid |=> word_valid && word_kind == $past(usr_kind))
		else $error("link word missing or wrong kind");
	a_data_pass: assert property (ce && usr_valid && usr_kind == ces_pkg::KIND_DATA |=> word_data == $past(usr_data))
		else $error("data word altered");
	a_bip_upper: assert property (mode == ces_pkg::CES_MODE_TYPE_TWO && usr_valid
		&& usr_kind == ces_pkg::KIND_CHECK |=> word_data[31:16] == 16'h0000)
		else $error("parity check word upper half not zero");
	a_slot_sum: assert property (mode == ces_pkg::CES_MODE_TYPE_ONE && usr_valid
		&& usr_kind == ces_pkg::KIND_HEADER |=> word_data[7:0] == $past(sum_in))
		else $error("header sum wrong");
	a_clean_crc: assert property (mode != ces_pkg::CES_MODE_LINE |=> !near_end_errored_block_flag)
		else $error("errored block on clean link");
	a_group_pass: assert property (usr_group_valid |=> group_valid && group_data == $past(usr_group))
		else $error("code group lost");
	a_cgf_fire: assert property (group_valid && group_data == 10'h3FF |=> code_group_fail_flag)
		else $error("illegal group not flagged");
	a_degr_flag: assert property (second_tick |=>
		degraded_period_flag == (errored_block_count_per_second >= $past(degrade_threshold)))
		else $error("degraded flag disagrees with count");
	a_count_hold: assert property (!second_tick |=> $stable(errored_block_count_per_second))
		else $error("count moved between ticks");
	a_flag_hold: assert property (!second_tick |=> $stable(degraded_period_flag))
		else $error("degraded flag moved between ticks");
endmodule

// >>> test/channel_error_supervision_test.sv
// Purpose: Source and sink end to end, faults injected on a second link
// Assumes: 100 MHz clock, inputs moved 1 ns after the rising edge
// Notes:   Second sink sees a bench copy of the stream with chosen faults

`timescale 1ns/100ps

module channel_error_supervision_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                  sys_clk = 1'h0;
	logic                  resetn = 1'h0;
	ces_pkg::ces_mode_type mode = ces_pkg::CES_MODE_GENERIC;
	logic                  usr_valid = 1'h0;
	logic [2:0]            usr_kind = 3'h0;
	logic [31:0]           usr_data = 32'h00000000;
	logic                  usr_group_valid = 1'h0;
	logic [9:0]            usr_group = 10'h000;
	logic [23:0]           degrade_threshold = 24'h000002;
	logic                  ssf = 1'h0;
	logic                  aid = 1'h0;
	logic                  second_tick = 1'h0;
	logic                  eb_a, cgf_a, dsp_a, eb_b, cgf_b, osf_b, dsp_b, inv_b;
	logic [23:0]           cnt_a, cnt_b;
	logic [31:0]           crc_acc = ces_pkg::CRC_SEED;
	logic [15:0]           bip_acc = ces_pkg::BIP_SEED;
	int                    errors = 0, compares = 0, eb_n = 0, cgf_n = 0, osf_n = 0;

	ces_link_if link();
	ces_link_if link_b();

	always #5 sys_clk = ~sys_clk;

	ces_source u_ces_source (.sys_clk(sys_clk), .resetn(resetn), .ce(1'h1), .mode(mode), .usr_valid(usr_valid),
		.usr_kind(usr_kind), .usr_data(usr_data), .usr_group_valid(usr_group_valid), .usr_group(usr_group), .link(link));
	ces_sink u_ces_sink (.sys_clk(sys_clk), .resetn(resetn), .ce(1'h1), .mode(mode),
		.degrade_threshold(degrade_threshold), .server_signal_fail(ssf), .alarm_indication_defect(aid),
		.second_tick(second_tick), .link(link),
		.near_end_errored_block_flag(eb_a), .code_group_fail_flag(cgf_a), .ordered_set_fail_flag(),
		.degraded_period_flag(dsp_a), .errored_block_count_per_second(cnt_a), .threshold_invalid());
	ces_sink u_ces_sink_b (.sys_clk(sys_clk), .resetn(resetn), .ce(1'h1), .mode(mode),
		.degrade_threshold(degrade_threshold), .server_signal_fail(ssf), .alarm_indication_defect(aid),
		.second_tick(second_tick), .link(link_b),
		.near_end_errored_block_flag(eb_b), .code_group_fail_flag(cgf_b), .ordered_set_fail_flag(osf_b),
		.degraded_period_flag(dsp_b), .errored_block_count_per_second(cnt_b), .threshold_invalid(inv_b));
	ces_check_sva u_ces_check_sva (.sys_clk(sys_clk), .resetn(resetn), .ce(1'h1), .mode(mode), .usr_valid(usr_valid),
		.usr_kind(usr_kind), .usr_data(usr_data), .usr_group_valid(usr_group_valid), .usr_group(usr_group),
		.word_valid(link.word_valid), .word_kind(link.word_kind), .word_data(link.word_data),
		.group_valid(link.group_valid), .group_data(link.group_data), .second_tick(second_tick),
		.degrade_threshold(degrade_threshold), .near_end_errored_block_flag(eb_a), .code_group_fail_flag(cgf_a),
		.degraded_period_flag(dsp_a), .errored_block_count_per_second(cnt_a));

	// Pulses last one cycle, so count them rather than guess the cycle
	always @(posedge sys_clk) begin
		if (eb_b === 1'h1) eb_n <= eb_n + 1;
		if (cgf_b === 1'h1) cgf_n <= cgf_n + 1;
		if (osf_b === 1'h1) osf_n <= osf_n + 1;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check_value(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] crc_step(logic [31:0] c, logic [31:0] d);
		for (int i = 31; i >= 0; i--) c = {c[30:0], 1'h0} ^ ((c[31] ^ d[i]) ? ces_pkg::CRC_POLY : 32'h00000000);
		return c;
	endfunction

	// Second link gets the correct code xor err, so err picks the fault
	task automatic drive(input logic [2:0] kind, input logic [31:0] data, input logic [31:0] err);
		logic [31:0] w;
		w = data;
		if (kind == ces_pkg::KIND_DATA) begin
			crc_acc = crc_step(crc_acc, data);
			bip_acc = bip_acc ^ data[31:16] ^ data[15:0];
		end
		if (kind == ces_pkg::KIND_CHECK) begin
			w = (mode == ces_pkg::CES_MODE_TYPE_TWO) ? {16'h0000, bip_acc} : crc_acc ^ ces_pkg::CRC_OUT_XOR;
			crc_acc = ces_pkg::CRC_SEED;
			bip_acc = ces_pkg::BIP_SEED;
		end
		if (mode == ces_pkg::CES_MODE_TYPE_ONE && (kind == ces_pkg::KIND_HEADER || kind == ces_pkg::KIND_TRAILER))
			w[7:0] = data[31:24] ^ data[23:16] ^ data[15:8];
		{usr_valid, usr_kind, usr_data} = {1'h1, kind, data};
		{link_b.word_valid, link_b.word_kind, link_b.word_data} = {1'h1, kind, w ^ err};
		@(posedge sys_clk); #1;
	endtask

	task automatic grp(input logic [9:0] g);
		{usr_group_valid, usr_group, link_b.group_valid, link_b.group_data} = {1'h1, g, 1'h1, g};
		@(posedge sys_clk); #1;
	endtask

	// Released lines show inverted data so stale values cannot pass
	task automatic idle(input int n);
		{usr_valid, usr_group_valid, link_b.word_valid, link_b.group_valid} = 4'h0;
		link_b.word_data = ~link_b.word_data;
		link_b.group_data = ~link_b.group_data;
		repeat (n) begin
			@(posedge sys_clk); #1;
		end
	endtask

	task automatic tick();
		second_tick = 1'h1;
		@(posedge sys_clk); #1;
		second_tick = 1'h0;
		@(posedge sys_clk); #1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_generic();
		int n0;
		n0 = eb_n;
		mode = ces_pkg::CES_MODE_GENERIC;
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'h12345678, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'hA5A5F00F, 32'h00000000);
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'h0000FFFF, 32'h00000000);
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h80000000);
		idle(3);
		check_value(32'(eb_n - n0), 32'h00000001);
	endtask

	task automatic t_type_one();
		int n0;
		n0 = eb_n;
		mode = ces_pkg::CES_MODE_TYPE_ONE;
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_HEADER, 32'h11223300, 32'h00000001);
		drive(ces_pkg::KIND_DATA, 32'hCAFE0001, 32'h00000000);
		drive(ces_pkg::KIND_TRAILER, 32'h44556600, 32'h00000002);
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_HEADER, 32'h01020300, 32'h00000000);
		drive(ces_pkg::KIND_TRAILER, 32'h0A0B0C00, 32'h00000000);
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'h00C0FFEE, 32'h00000000);
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00010000);
		idle(3);
		check_value(32'(eb_n - n0), 32'h00000002);
	endtask

	task automatic t_type_two();
		int n0;
		n0 = eb_n;
		mode = ces_pkg::CES_MODE_TYPE_TWO;
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'hFFFF0001, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'h8000ABCD, 32'h00000000);
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'h00010002, 32'h00000000);
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000100);
		idle(3);
		check_value(32'(eb_n - n0), 32'h00000001);
	endtask

	task automatic t_gated();
		int n0;
		n0 = eb_n;
		mode = ces_pkg::CES_MODE_GENERIC;
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000000);
		drive(ces_pkg::KIND_DATA, 32'h13572468, 32'h00000000);
		ssf = 1'h1;
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000001);
		{ssf, aid} = 2'h1;
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'h00000004);
		aid = 1'h0;
		idle(3);
		check_value(32'(eb_n - n0), 32'h00000000);
	endtask

	task automatic t_line();
		int e0, c0, o0;
		{e0, c0, o0} = {eb_n, cgf_n, osf_n};
		mode = ces_pkg::CES_MODE_LINE;
		drive(ces_pkg::KIND_CHECK, 32'h00000000, 32'hFFFFFFFF);
		grp(ces_pkg::COMMA_NEG);
		grp(ces_pkg::COMMA_POS);
		grp(10'h1C5);
		grp(10'h3FF);
		grp(10'h1C5);
		idle(3);
		check_value(32'(cgf_n - c0), 32'h00000001);
		check_value(32'(osf_n - o0), 32'h00000001);
		check_value(32'(eb_n - e0), 32'h00000002);
	endtask

	task automatic t_second();
		tick();
		grp(10'h3FF);
		grp(10'h3FF);
		idle(2);
		tick();
		check_value({8'h00, cnt_b}, 32'h00000002);
		check_value({31'h0, dsp_b}, 32'h00000001);
		grp(10'h3FF);
		idle(2);
		tick();
		check_value({8'h00, cnt_b}, 32'h00000001);
		check_value({31'h0, dsp_b}, 32'h00000000);
		degrade_threshold = 24'h000000;
		idle(2);
		check_value({31'h0, inv_b}, 32'h00000001);
		degrade_threshold = 24'h000002;
	endtask

	task automatic tally_and_finish();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		{link_b.word_valid, link_b.word_kind, link_b.word_data} = 36'h0;
		{link_b.group_valid, link_b.group_data} = 11'h0;
		repeat (16) @(posedge sys_clk);
		#1;
		resetn = 1'h1;
		t_generic();
		t_type_one();
		t_type_two();
		t_gated();
		t_line();
		t_second();
		tally_and_finish();
	end

	// Tests need under a hundred cycles; ten thousand means a hang
	initial begin
		#100000;
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule
